// ### mfv_pkg.sv
// Package for the MAC flow control, VLAN and wake filter block.
// Assumes a 32-bit APB slave; registers sit one per aligned word.
package mfv_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [3:0] FLOW_IDX = 4'h8;
    localparam logic [3:0] VLAN_TAG_ONE_MATCH_IDX = 4'h9;
    localparam logic [3:0] VLAN_TAG_TWO_MATCH_IDX = 4'hA;
    localparam logic [3:0] WAKE_IDX = 4'hB;
    // Own control/status word for line-side settings
    localparam logic [3:0] CTRL_IDX = 4'hD;
    // Flow register fields
    localparam int FLOW_BUSY_BIT = 0;
    localparam int FLOW_EN_BIT = 1;
    localparam int FLOW_PASS_BIT = 2;
    localparam int FLOW_PT_LSB = 16;
    // Control register fields
    localparam int CTRL_FDX_BIT = 0;
    localparam int CTRL_TXEN_BIT = 1;
    localparam int CTRL_PROMISC_BIT = 2;
    localparam int CTRL_PAUSE_REQ_BIT = 3;
    localparam int CTRL_BP_REQ_BIT = 4;
    // Reset values
    localparam logic [31:0] REG_RESET = 32'h00000000;
    // Frame lengths in bytes
    localparam logic [10:0] LEN_UNTAGGED = 11'd1518;
    localparam logic [10:0] LEN_TAGGED = 11'd1522;
    // Pause quantum: 512 bit times; slot length in pclk cycles
    localparam int SLOT_BITS = 512;
    localparam int BITS_PER_CYCLE = 1;
    localparam int SLOT_CYCLES = SLOT_BITS / BITS_PER_CYCLE;
    // Cycles a transmitted pause frame occupies the line (64 bytes)
    localparam int PAUSE_TX_CYCLES = 64 * 8 / BITS_PER_CYCLE;
    localparam int WAKE_WORDS = 8;
    // Pause frame type and opcode
    localparam logic [15:0] PAUSE_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
endpackage

// ### mfv_flow_vlan_wake.sv
// MAC flow control, VLAN length extension and wake filter loader.
// Assumes an APB master on pclk and a byte-wide receive stream on pclk.
//
// Operation
// - Pass bit set marks received valid pause frame in status filter flag.
// - Pass bit clear leaves the status filter flag clear for pause frames that pass the address filter.
// - Pause frames act only in full duplex with flow control enabled.
// - All frames go to host; host drops by status word.
// - Promiscuous address filtering overrides the pass-control setting.
// - Valid pause holds transmitter for pause time times slot time.
// - Flow control disabled means received pause frames are not acted on; pause frame requests are still sent.
// - In half duplex the enable bit turns on backpressure instead.
// - Busy flag high while pause frame or backpressure is sent.
// - First tag compared with frame bytes 13 and 14.
// - Second tag compared with frame bytes 13 and 14.
// - Tagged frames get 1522 byte limit instead of 1518.
// - Reset points wake load pointer at filter word zero.
// - Each port write stores at pointer then advances it.
// - Pointer wraps to first entry after eighth word.
// - Programmed pause time goes into transmitted pause frames.
// - No pause frames or backpressure while transmitter disabled.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module mfv_flow_vlan_wake
    import mfv_pkg::*;
#(
    parameter int WORDS = WAKE_WORDS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_good,
    input wire logic rx_addr_pass,
    // Receive status
    output logic rx_stat_valid,
    output logic rx_stat_filter,
    output logic rx_stat_vlan,
    output logic rx_stat_too_long,
    output logic rx_stat_is_pause,
    // Transmit side
    output logic tx_hold,
    output logic tx_pause_send,
    output logic [15:0] tx_pause_time,
    output logic tx_backpressure,
    // Wake filter contents, flattened
    output logic [WORDS*32-1:0] wake_filter_data
);
    localparam int PW = $clog2(WORDS);

    // Registers
    logic [15:0] pause_time_value_reg;
    logic flow_ctrl_enable_reg, pass_control_frames_reg, flow_busy_reg;
    logic [15:0] first_tag_ident_reg, second_tag_ident_reg;
    logic [4:0] ctrl_reg;
    logic [PW-1:0] wake_ptr_reg;
    logic [31:0] wake_mem_reg [WORDS];
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    // Pause sender state is declared early: the control register clears
    // its request bit in the same cycle that the sender takes it.
    logic [$clog2(PAUSE_TX_CYCLES+1)-1:0] ptx_reg;
    wire logic pause_start;

    // Bus decode
    // Only word addresses are decoded; the two low address bits are
    // ignored, so a byte offset inside a word aliases onto that word.
    // Writes land only on the edge where pready is seen high; an access phase
    // held past that edge writes the wake port again on every second edge.
    wire logic [5:0] word_idx = paddr[7:2];
    wire logic access = psel && penable;
    wire logic wr_en = access && pwrite;
    wire logic hit_flow = (word_idx == {2'b00, FLOW_IDX});
    wire logic hit_v1 = (word_idx == {2'b00, VLAN_TAG_ONE_MATCH_IDX});
    wire logic hit_v2 = (word_idx == {2'b00, VLAN_TAG_TWO_MATCH_IDX});
    wire logic hit_wake = (word_idx == {2'b00, WAKE_IDX});
    wire logic hit_ctrl = (word_idx == {2'b00, CTRL_IDX});
    wire logic mapped = hit_flow | hit_v1 | hit_v2 | hit_wake | hit_ctrl;
    wire logic fdx = ctrl_reg[CTRL_FDX_BIT];
    wire logic tx_en = ctrl_reg[CTRL_TXEN_BIT];
    wire logic promisc = ctrl_reg[CTRL_PROMISC_BIT];

    // Read mux; wake port reads as zero
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        if (hit_flow)
            rd_val = {pause_time_value_reg, 13'h0000,
                      pass_control_frames_reg, flow_ctrl_enable_reg,
                      flow_busy_reg};
        else if (hit_v1)
            rd_val = {16'h0000, first_tag_ident_reg};
        else if (hit_v2)
            rd_val = {16'h0000, second_tag_ident_reg};
        else if (hit_ctrl)
            rd_val = {27'h0000000, ctrl_reg};
    end

    // APB answer: one wait state, ready in the access cycle's second edge
    // First access edge: ready, error and read data are registered.
    // Second access edge: the master sees ready and the write lands.
    // Ready drops again on that second edge, so a held access phase
    // gets a fresh answer on every second edge for the same transfer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= REG_RESET;
        end else begin
            pready_reg <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && !mapped;
            prdata_reg <= (access && !pready_reg && !pwrite) ? rd_val
                                                            : 32'h00000000;
        end
    end
    wire logic wr_take = wr_en && pready_reg && mapped;

    // Flow, tag and control registers
    // The busy bit is status only: the written value in bit 0 is dropped.
    // Software is expected to wait for busy low before writing here;
    // nothing blocks a write made while a pause frame is still going out.
    // A write that meets the request self-clear keeps the written value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_time_value_reg <= 16'h0000;
            flow_ctrl_enable_reg <= 1'b0;
            pass_control_frames_reg <= 1'b0;
            first_tag_ident_reg <= 16'h0000;
            second_tag_ident_reg <= 16'h0000;
            ctrl_reg <= 5'h00;
        end else if (wr_take) begin
            if (hit_flow) begin
                pause_time_value_reg <= pwdata[31:16];
                flow_ctrl_enable_reg <= pwdata[FLOW_EN_BIT];
                pass_control_frames_reg <= pwdata[FLOW_PASS_BIT];
            end
            if (hit_v1)
                first_tag_ident_reg <= pwdata[15:0];
            if (hit_v2)
                second_tag_ident_reg <= pwdata[15:0];
            if (hit_ctrl)
                ctrl_reg <= pwdata[4:0];
        end else begin
            // The pause request bit self-clears when the sender takes it in a cycle with no register write
            if (pause_start)
                ctrl_reg[CTRL_PAUSE_REQ_BIT] <= 1'b0;
        end
    end

    // Wake port load pointer. Reads never move it; only a write that is
    // answered advances it, so a wait state cannot skip an entry.
    // store and advance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wake_ptr_reg <= '0;
        else if (wr_take && hit_wake)
            wake_ptr_reg <= (wake_ptr_reg == PW'(WORDS - 1)) ? '0
                                                  : wake_ptr_reg + 1'b1;
    end

    // Wake filter storage, one word per entry
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_wake
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    wake_mem_reg[gi] <= REG_RESET;
                else if (wr_take && hit_wake && wake_ptr_reg == PW'(gi))
                    wake_mem_reg[gi] <= pwdata;
            end
            assign wake_filter_data[gi*32 +: 32] = wake_mem_reg[gi];
        end
    endgenerate

    // Receive byte counter and captured header bytes
    // The first byte of a frame restarts the index, so a frame that was
    // cut short never shifts the header bytes of the next one.
    // The counter saturates at 2047, but the 11-bit length then wraps to zero, so frames of 2048 bytes or more are not flagged as long.
    // Header bytes from a short frame stay from the previous frame; such
    // frames are runts and their tag and pause flags carry no meaning.
    logic [10:0] rx_cnt_reg;
    logic [15:0] rx_type_reg, rx_op_reg, rx_quanta_reg;
    wire logic [10:0] cur_idx = rx_sof ? 11'd0 : rx_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_reg <= 11'd0;
            rx_type_reg <= 16'h0000;
            rx_op_reg <= 16'h0000;
            rx_quanta_reg <= 16'h0000;
        end else if (rx_valid) begin
            rx_cnt_reg <= (cur_idx == 11'h7FF) ? cur_idx : cur_idx + 11'd1;
            case (cur_idx)
                11'd12: rx_type_reg[15:8] <= rx_data;
                11'd13: rx_type_reg[7:0] <= rx_data;
                11'd14: rx_op_reg[15:8] <= rx_data;
                11'd15: rx_op_reg[7:0] <= rx_data;
                11'd16: rx_quanta_reg[15:8] <= rx_data;
                11'd17: rx_quanta_reg[7:0] <= rx_data;
                default: ;
            endcase
        end
    end

    wire logic vlan_one = (rx_type_reg == first_tag_ident_reg);
    wire logic vlan_two = (rx_type_reg == second_tag_ident_reg);
    wire logic is_vlan = vlan_one | vlan_two;
    wire logic [10:0] len_limit = is_vlan ? LEN_TAGGED : LEN_UNTAGGED;
    wire logic [10:0] frame_len = cur_idx + 11'd1;
    wire logic is_pause = (rx_type_reg == PAUSE_TYPE) &&
                          (rx_op_reg == PAUSE_OPCODE) && rx_good;
    wire logic frame_end = rx_valid && rx_eof;
    wire logic pause_act = frame_end && is_pause && fdx &&
                           flow_ctrl_enable_reg;

    // Status flags are only meaningful in the cycle that valid is high;
    // outside it they are held at zero so the host never sees stale bits.
    // every frame reported
    wire logic filt_next = promisc ? 1'b0 :
                           (!rx_addr_pass ||
                            (is_pause && pass_control_frames_reg));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_stat_valid <= 1'b0;
            rx_stat_filter <= 1'b0;
            rx_stat_vlan <= 1'b0;
            rx_stat_too_long <= 1'b0;
            rx_stat_is_pause <= 1'b0;
        end else begin
            rx_stat_valid <= frame_end;
            rx_stat_filter <= frame_end && filt_next;
            rx_stat_vlan <= frame_end && is_vlan;
            rx_stat_too_long <= frame_end && (frame_len > len_limit);
            rx_stat_is_pause <= frame_end && is_pause;
        end
    end

    // Pause timer: the slot counter divides pclk down to one quantum.
    // A new pause frame reloads the count, so a zero quantum releases
    // the transmitter early. Dropping the enable or full duplex clears
    // the count at once rather than letting a stale pause run out.
    // hold for quanta times slot
    logic [15:0] quanta_reg;
    logic [$clog2(SLOT_CYCLES)-1:0] slot_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quanta_reg <= 16'h0000;
            slot_reg <= '0;
        end else if (pause_act) begin
            quanta_reg <= rx_quanta_reg;
            slot_reg <= '0;
        end else if (!flow_ctrl_enable_reg || !fdx) begin
            quanta_reg <= 16'h0000;
        end else if (quanta_reg != 16'h0000) begin
            slot_reg <= slot_reg + 1'b1;
            if (slot_reg == $bits(slot_reg)'(SLOT_CYCLES - 1))
                quanta_reg <= quanta_reg - 16'h0001;
        end
    end

    // Pause frame transmission timer
    // A request waits while a frame is on the line; it is taken only
    // once the timer has run down, so frames never overlap.
    // sender gated by transmitter
    assign pause_start = tx_en && fdx && ctrl_reg[CTRL_PAUSE_REQ_BIT] &&
                         ptx_reg == '0;
    wire logic bp_on = tx_en && !fdx && flow_ctrl_enable_reg &&
                       ctrl_reg[CTRL_BP_REQ_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ptx_reg <= '0;
        else if (pause_start)
            ptx_reg <= $bits(ptx_reg)'(PAUSE_TX_CYCLES);
        else if (ptx_reg != '0)
            ptx_reg <= ptx_reg - 1'b1;
    end

    // Busy covers the whole pause frame time and the backpressure level.
    // The transmitter hold starts the cycle after the pause frame ends,
    // and only when the frame asks for a non-zero pause.
    // busy while sending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_busy_reg <= 1'b0;
            tx_hold <= 1'b0;
            tx_pause_send <= 1'b0;
            tx_pause_time <= 16'h0000;
            tx_backpressure <= 1'b0;
        end else begin
            flow_busy_reg <= pause_start || (ptx_reg > 1) || bp_on;
            tx_hold <= (pause_act && rx_quanta_reg != 16'h0000) ||
                       (quanta_reg != 16'h0000 &&
                       !(quanta_reg == 16'h0001 &&
                         slot_reg == $bits(slot_reg)'(SLOT_CYCLES - 1)));
            tx_pause_send <= pause_start;
            tx_pause_time <= pause_time_value_reg;
            tx_backpressure <= bp_on;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule // mfv_flow_vlan_wake
`default_nettype wire

// ### mfv_checker.sv
// Checker for the flow control, tag and wake filter block.
// Assumes it is bound to the block top and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module mfv_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Receive and transmit
    input wire logic rx_valid,
    input wire logic rx_eof,
    input wire logic rx_stat_valid,
    input wire logic rx_stat_filter,
    input wire logic rx_stat_vlan,
    input wire logic rx_stat_too_long,
    input wire logic rx_stat_is_pause,
    input wire logic tx_hold,
    input wire logic tx_pause_send
);
    // Words that decode to a register
    wire logic mapped;
    assign mapped = paddr[7:2] inside {6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0D};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_wait_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stuck");
    wake_zero_a: assert property (pready && !pwrite && paddr == 8'h2C
        |-> prdata == 32'h00000000) else $error("wake port read not zero");
    unmapped_err_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    stat_time_a: assert property (rx_valid && rx_eof |=> rx_stat_valid)
        else $error("status missing");
    stat_quiet_a: assert property (!rx_stat_valid |-> !(rx_stat_filter
        || rx_stat_vlan || rx_stat_too_long || rx_stat_is_pause))
        else $error("status outside pulse");
    send_pulse_a: assert property (tx_pause_send |=> !tx_pause_send)
        else $error("pause send not a pulse");
    hold_cause_a: assert property ($rose(tx_hold)
        |-> rx_stat_valid && rx_stat_is_pause) else $error("hold no cause");
    hold_min_a: assert property ($rose(tx_hold) |-> tx_hold[*8])
        else $error("hold too short");
endmodule // mfv_checker
bind mfv_flow_vlan_wake mfv_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_eof(rx_eof), .rx_stat_valid(rx_stat_valid),
    .rx_stat_filter(rx_stat_filter), .rx_stat_vlan(rx_stat_vlan),
    .rx_stat_too_long(rx_stat_too_long),
    .rx_stat_is_pause(rx_stat_is_pause), .tx_hold(tx_hold),
    .tx_pause_send(tx_pause_send));
`default_nettype wire

// ### mfv_link_partner.sv
// Link partner model: plays received frames into the byte stream.
// Assumes send is called just after a rising pclk edge.
`timescale 1ns/1ns
`default_nettype none
module mfv_link_partner (
    // Clock
    input wire logic pclk,
    // Byte stream toward the block
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_sof = 1'b0,
    output logic rx_eof = 1'b0,
    output logic rx_good = 1'b0,
    output logic rx_addr_pass = 1'b0
);
    // One frame; type at bytes 12-13, opcode 14-15, quanta 16-17
    task automatic send(input logic [15:0] ty, op, qu, input int len,
                        input logic ap);
        logic [7:0] b;
        for (int i = 0; i < len; i++) begin
            b = 8'($urandom);
            case (i)
                12: b = ty[15:8];
                13: b = ty[7:0];
                14: b = op[15:8];
                15: b = op[7:0];
                16: b = qu[15:8];
                17: b = qu[7:0];
                default: ;
            endcase
            rx_valid <= 1'b1;
            rx_data <= b;
            rx_sof <= (i == 0);
            rx_eof <= (i == len - 1);
            rx_good <= 1'b1;
            rx_addr_pass <= ap;
            @(posedge pclk);
        end
        // Idle: lines no longer hold the last frame values
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        rx_data <= ~b;
        rx_good <= 1'b0;
        rx_addr_pass <= ~ap;
    endtask
endmodule // mfv_link_partner
`default_nettype wire

// ### mfv_flow_vlan_wake_tb_top.sv
// Testbench for the flow control, tag and wake filter block.
// Assumes the link partner model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module mfv_flow_vlan_wake_tb_top;
    import mfv_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, e, prm = 1'b0, pas = 1'b0;
    logic [7:0] paddr = 8'h00, rx_data;
    logic [31:0] pwdata = 32'h00000000, prdata, r, d;
    logic rx_valid, rx_sof, rx_eof, rx_good, rx_addr_pass, tx_hold;
    logic rx_stat_valid, rx_stat_filter, rx_stat_vlan, rx_stat_too_long;
    logic rx_stat_is_pause, tx_pause_send, tx_backpressure;
    logic [15:0] tx_pause_time, pt, v1, v2;
    logic [255:0] wfd;
    logic [31:0] wk[8] = '{default: 32'h00000000};
    int error_cnt = 0, cmp_count = 0, sends = 0, n;
    mfv_flow_vlan_wake u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
        .rx_eof(rx_eof), .rx_good(rx_good), .rx_addr_pass(rx_addr_pass),
        .rx_stat_valid(rx_stat_valid), .rx_stat_filter(rx_stat_filter),
        .rx_stat_vlan(rx_stat_vlan), .rx_stat_too_long(rx_stat_too_long),
        .rx_stat_is_pause(rx_stat_is_pause), .tx_hold(tx_hold),
        .tx_pause_send(tx_pause_send), .tx_pause_time(tx_pause_time),
        .tx_backpressure(tx_backpressure), .wake_filter_data(wfd));
    mfv_link_partner u_lp (.pclk(pclk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
        .rx_good(rx_good), .rx_addr_pass(rx_addr_pass));
    always #10 pclk = ~pclk;
    // Count pause frame starts
    always @(posedge pclk) if (tx_pause_send === 1'b1) sends++;
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, x);
        cmp_count++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // One APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            end_of_test();
        end
        @(posedge pclk);
    endtask
    // Frame in, status compared with the model
    task automatic frame(input logic [15:0] ty, qu, input int len,
                         input logic ap);
        logic pz, tg;
        pz = (ty == PAUSE_TYPE);
        tg = (ty == v1) || (ty == v2);
        u_lp.send(ty, PAUSE_OPCODE, qu, len, ap);
        @(posedge pclk);
        chk(rx_stat_valid, 1);
        chk(rx_stat_vlan, tg);
        chk(rx_stat_too_long, len > (tg ? 1522 : 1518));
        chk(rx_stat_filter, !prm && (!ap || (pz && pas)));
        chk(rx_stat_is_pause, pz);
    endtask
    task automatic quiet();
        repeat (20) begin
            @(posedge pclk);
            chk(tx_hold, 0);
        end
    endtask
    initial begin
        void'($urandom(37808));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped word
        for (int i = 0; i < 5; i++) begin
            apb(0, 8'h20 + 8'(4 * i), 0);
            chk(r, 32'h0);
            chk(e, i == 4);
        end
        // Wake loading with wrap and a read in between
        for (int i = 0; i < 11; i++) begin
            d = $urandom;
            apb(1, 8'h2C, d);
            wk[i % 8] = d;
            if (i == 4) apb(0, 8'h2C, 0);
        end
        for (int i = 0; i < 8; i++) chk(wfd[32*i+:32], wk[i]);
        // Mid-run reset: pointer was left at word three
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        d = $urandom;
        apb(1, 8'h2C, d);
        chk(wfd[31:0], d);
        chk(wfd[63:32], 32'h0);
        v1 = 16'h8100;
        v2 = 16'h9100;
        apb(1, 8'h24, {16'h0, v1});
        apb(1, 8'h28, {16'h0, v2});
        apb(0, 8'h28, 0);
        chk(r, {16'h0, v2});
        pt = 16'($urandom);
        pas = 1'b1;
        apb(1, 8'h34, 32'h00000003);
        apb(1, 8'h20, {pt, 16'h0006});
        apb(0, 8'h20, 0);
        chk(r, {pt, 16'h0006});
        frame(16'h8100, 0, 1522, 1);
        frame(16'h9100, 0, 1523, 1);
        frame(16'h0800, 0, 1519, 1);
        frame(16'h0800, 0, 1518, 0);
        prm = 1'b1;
        apb(1, 8'h34, 32'h00000007);
        frame(16'h0800, 0, 64, 0);
        frame(PAUSE_TYPE, 0, 64, 1);
        prm = 1'b0;
        apb(1, 8'h34, 32'h00000003);
        // Pause of one quantum
        frame(PAUSE_TYPE, 1, 64, 1);
        n = 0;
        while (tx_hold === 1'b1 && n < 2000) begin
            n++;
            @(posedge pclk);
        end
        chk(n, SLOT_CYCLES);
        pas = 1'b0;
        apb(1, 8'h20, {pt, 16'h0002});
        frame(PAUSE_TYPE, 0, 64, 1);
        apb(1, 8'h20, {pt, 16'h0000});
        u_lp.send(PAUSE_TYPE, PAUSE_OPCODE, 16'h0004, 64, 1);
        quiet();
        apb(1, 8'h20, {pt, 16'h0002});
        apb(1, 8'h34, 32'h00000002);
        u_lp.send(PAUSE_TYPE, PAUSE_OPCODE, 16'h0004, 64, 1);
        quiet();
        // Half duplex backpressure, then transmitter off
        apb(1, 8'h34, 32'h00000012);
        apb(0, 8'h20, 0);
        chk({tx_backpressure, r[0]}, 2'b11);
        apb(1, 8'h34, 32'h00000010);
        apb(0, 8'h20, 0);
        chk({tx_backpressure, r[0]}, 2'b00);
        // Pause frame request
        apb(1, 8'h34, 32'h0000000B);
        n = 0;
        do begin
            apb(0, 8'h20, 0);
            n++;
        end while (r[0] !== 1'b0 && n < 300);
        chk(sends, 1);
        chk(tx_pause_time, pt);
        chk(n > 1, 1);
        apb(1, 8'h34, 32'h00000009);
        repeat (20) @(posedge pclk);
        chk(sends, 1);
        end_of_test();
    end
endmodule // mfv_flow_vlan_wake_tb_top
`default_nettype wire
